/* File: tcl_pkg.sv */
// constants shared by the trigger and capture block
package tcl_pkg;
   localparam int TCL_NUM_WP    = 2;
   localparam int TCL_NUM_BP    = 4;
   localparam int TCL_WP_WIDTH  = 8;
   localparam int TCL_SMP_WIDTH = 16;
   localparam int TCL_DEPTH     = 32;
   localparam int TCL_FIFO_DEP  = 32;
   localparam logic TCL_WP_MODE_VALUE = 1'b0;
   localparam logic TCL_WP_MODE_TRANS = 1'b1;
endpackage : tcl_pkg

/* File: tcl_fifo.sv */
// parameterised fifo carrying upload words to the host
`timescale 1ns/100ps
module tcl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [AW:0]      cnt_ff, nxt_cnt;
   logic             wr, rd;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rp_ff];
   assign wr        = in_valid & in_ready;
   assign rd        = out_valid & out_ready;

   always_comb begin
      nxt_wp  = wr ? AW'(wp_ff + 1'b1) : wp_ff;
      nxt_rp  = rd ? AW'(rp_ff + 1'b1) : rp_ff;
      nxt_cnt = cnt_ff;
      if (wr && !rd) begin
         nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
      end else if (rd && !wr) begin
         nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   // storage needs no reset; only pointers define contents
   always_ff @(posedge clk) begin
      if (wr) begin
         mem_ff[wp_ff] <= in_data;
      end
   end
endmodule // tcl_fifo

/* File: tcl_capture.sv */
// trigger logic and sample memory with upload through a fifo
`timescale 1ns/100ps
module tcl_capture
   import tcl_pkg::*;
#(
   parameter int NUM_WP    = TCL_NUM_WP,
   parameter int NUM_BP    = TCL_NUM_BP,
   parameter int WP_WIDTH  = TCL_WP_WIDTH,
   parameter int SMP_WIDTH = TCL_SMP_WIDTH,
   parameter int DEPTH     = TCL_DEPTH
) (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic [NUM_WP-1:0][WP_WIDTH-1:0] wp_signals,
   input  wire logic [NUM_WP-1:0][WP_WIDTH-1:0] wp_value1,
   input  wire logic [NUM_WP-1:0][WP_WIDTH-1:0] wp_value2,
   input  wire logic [NUM_WP-1:0]            wp_mode,
   input  wire logic [NUM_WP-1:0]            wp_active,
   input  wire logic [NUM_BP-1:0]            bp_branch_cond,
   input  wire logic [NUM_BP-1:0]            bp_active,
   input  wire logic                         counter_event,
   input  wire logic [SMP_WIDTH-1:0]         sample_data,
   input  wire logic                         run_start,
   input  wire logic                         run_stop,
   output logic                              running,
   output logic                              triggered,
   output logic                              master_trigger,
   output logic [SMP_WIDTH-1:0]              up_data,
   output logic                              up_valid,
   input  wire logic                         up_ready,
   output logic                              up_done
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   typedef enum logic [1:0] {
      TCL_IDLE   = 2'b00,
      TCL_ARMED  = 2'b01,
      TCL_UPLOAD = 2'b11,
      TCL_DONE   = 2'b10
   } tcl_state_t;

   tcl_state_t       st_ff, nxt_st;
   logic [SMP_WIDTH-1:0] smp_mem_ff [DEPTH];
   logic [AW-1:0]    wa_ff, nxt_wa, ra_ff, nxt_ra;
   logic [AW:0]      left_ff, nxt_left;
   logic             full_ff, nxt_full;
   logic [NUM_WP-1:0][WP_WIDTH-1:0] prev_ff;
   logic [NUM_WP-1:0] wp_hit;
   logic             bp_term, wp_term, any_act;
   logic             smp_we, push, push_rdy;

   // watchpoint comparators, one per watchpoint
   genvar g;
   generate
      for (g = 0; g < NUM_WP; g++) begin : g_wp
         always_comb begin
            if (wp_mode[g] == TCL_WP_MODE_TRANS) begin
               wp_hit[g] = (prev_ff[g] == wp_value1[g]) &&
                           (wp_signals[g] == wp_value2[g]);
            end else begin
               wp_hit[g] = (wp_signals[g] == wp_value1[g]);
            end
         end
      end
   endgenerate

   // nested branch conditions arrive already ANDed from the design
   always_comb begin
      bp_term = (bp_active == '0)
                | |(bp_branch_cond & bp_active);
      wp_term = &(wp_hit | ~wp_active);
      any_act = (bp_active != '0) | (wp_active != '0);
   end
   assign master_trigger = bp_term & wp_term & any_act;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= wp_signals;
      end
   end

   assign smp_we = (st_ff == TCL_ARMED) && !master_trigger
                   && !counter_event && !run_stop;
   assign push   = (st_ff == TCL_UPLOAD);

   always_comb begin
      nxt_st   = st_ff;
      nxt_wa   = wa_ff;
      nxt_ra   = ra_ff;
      nxt_left = left_ff;
      nxt_full = full_ff;
      unique case (st_ff)
         TCL_IDLE, TCL_DONE: begin
            if (run_start) begin
               nxt_st   = TCL_ARMED;
               nxt_wa   = '0;
               nxt_full = 1'b0;
            end
         end
         TCL_ARMED: begin
            if (smp_we) begin
               nxt_wa = (wa_ff == LAST) ? '0 : AW'(wa_ff + 1'b1);
               if (wa_ff == LAST) begin
                  nxt_full = 1'b1;
               end
            end else begin
               nxt_st   = TCL_UPLOAD;
               nxt_ra   = full_ff ? wa_ff : '0;
               nxt_left = full_ff ? (AW+1)'(DEPTH) : {1'b0, wa_ff};
            end
         end
         TCL_UPLOAD: begin
            if (left_ff == '0) begin
               nxt_st = TCL_DONE;
            end else if (push_rdy) begin
               nxt_ra   = (ra_ff == LAST) ? '0 : AW'(ra_ff + 1'b1);
               nxt_left = (AW+1)'(left_ff - 1'b1);
            end
         end
         default: nxt_st = TCL_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff   <= TCL_IDLE;
         wa_ff   <= '0;
         ra_ff   <= '0;
         left_ff <= '0;
         full_ff <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         wa_ff   <= nxt_wa;
         ra_ff   <= nxt_ra;
         left_ff <= nxt_left;
         full_ff <= nxt_full;
      end
   end

   // circular memory: oldest sample is uploaded first
   always_ff @(posedge clk) begin
      if (smp_we) begin
         smp_mem_ff[wa_ff] <= sample_data;
      end
   end

   assign running   = (st_ff == TCL_ARMED);
   assign triggered = (st_ff == TCL_UPLOAD) || (st_ff == TCL_DONE);
   assign up_done   = (st_ff == TCL_DONE);

   tcl_fifo #(
      .WIDTH (SMP_WIDTH),
      .DEPTH (TCL_FIFO_DEP)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (smp_mem_ff[ra_ff]),
      .in_valid  (push && (left_ff != '0)),
      .in_ready  (push_rdy),
      .out_data  (up_data),
      .out_valid (up_valid),
      .out_ready (up_ready)
   );

   property p_freeze;
      @(posedge clk) disable iff (rst)
      (running && master_trigger) |=> (st_ff == TCL_UPLOAD) && $stable(wa_ff);
   endproperty
   a_freeze: assert property (p_freeze) else $error("no freeze");

   property p_write;
      @(posedge clk) disable iff (rst)
      smp_we && (wa_ff != LAST) |=> (wa_ff == AW'($past(wa_ff) + 1'b1));
   endproperty
   a_write: assert property (p_write) else $error("no advance");

   property p_none;
      @(posedge clk) disable iff (rst)
      (bp_active == '0) && (wp_active == '0) |-> !master_trigger;
   endproperty
   a_none: assert property (p_none) else $error("idle trigger");

   property p_bp_or;
      @(posedge clk) disable iff (rst)
      (wp_active == '0) && |(bp_active & bp_branch_cond) |-> master_trigger;
   endproperty
   a_bp_or: assert property (p_bp_or) else $error("bp or lost");

   property p_wp_and;
      @(posedge clk) disable iff (rst)
      |(wp_active & ~wp_hit) |-> !master_trigger;
   endproperty
   a_wp_and: assert property (p_wp_and) else $error("wp and");

   property p_bp_need;
      @(posedge clk) disable iff (rst)
      (bp_active != '0) && !(|(bp_active & bp_branch_cond)) |-> !master_trigger;
   endproperty
   a_bp_need: assert property (p_bp_need) else $error("bp need");

   property p_value;
      @(posedge clk) disable iff (rst)
      wp_active[0] && (wp_mode[0] == TCL_WP_MODE_VALUE)
      && (wp_signals[0] == wp_value1[0]) |-> wp_hit[0];
   endproperty
   a_value: assert property (p_value) else $error("wp value");

   property p_upload;
      @(posedge clk) disable iff (rst)
      (st_ff == TCL_UPLOAD) && (left_ff == '0) |=> up_done;
   endproperty
   a_upload: assert property (p_upload) else $error("upload end");
endmodule // tcl_capture

/* File: tcl_host_model.sv */
// host side model that drains the upload stream
`timescale 1ns/100ps
module tcl_host_model
   import tcl_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     slow,
   input  wire logic                     clr,
   input  wire logic [TCL_SMP_WIDTH-1:0] up_data,
   input  wire logic                     up_valid,
   output logic                          up_ready
);
   logic [TCL_SMP_WIDTH-1:0] got [0:63];
   int                       n;
   logic [1:0]               ph_ff;
   // slow host takes one word in four so the fifo backs up
   assign up_ready = !slow || (ph_ff == 2'h0);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_ff <= 2'h0;
         n <= 0;
      end else begin
         ph_ff <= ph_ff + 2'h1;
         if (clr) begin
            n <= 0;
         end else if (up_valid && up_ready) begin
            got[n[5:0]] <= up_data;
            n <= n + 1;
         end
      end
   end
endmodule // tcl_host_model

/* File: tb_trigger_capture_logic.sv */
// self-checking bench for the trigger and capture block
`timescale 1ns/100ps
module tb_trigger_capture_logic;
   import tcl_pkg::*;
   logic clk, rst, counter_event, run_start, run_stop, up_ready, slow;
   logic running, triggered, master_trigger, up_valid, up_done, clr;
   logic [TCL_NUM_WP-1:0][TCL_WP_WIDTH-1:0] wp_signals, wp_value1;
   logic [TCL_NUM_WP-1:0][TCL_WP_WIDTH-1:0] wp_value2;
   logic [TCL_NUM_WP-1:0]    wp_mode, wp_active;
   logic [TCL_NUM_BP-1:0]    bp_branch_cond, bp_active;
   logic [TCL_SMP_WIDTH-1:0] sample_data, up_data, first;
   int                       err_total, checks_done, cyc;
   tcl_capture u_dut (.clk, .rst, .wp_signals, .wp_value1, .wp_value2,
      .wp_mode, .wp_active, .bp_branch_cond, .bp_active, .counter_event,
      .sample_data, .run_start, .run_stop, .running, .triggered,
      .master_trigger, .up_data, .up_valid, .up_ready, .up_done);
   tcl_host_model u_host (.clk, .rst, .slow, .clr, .up_data, .up_valid,
      .up_ready);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // a running count makes every stored word identifiable
   always @(posedge clk) sample_data <= #1 sample_data + 16'h0001;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // an x expectation only steps the transition history
   task automatic trig(logic [1:0] wa, logic [3:0] ba, logic [3:0] bc,
                       logic [7:0] s0, logic [7:0] s1, logic e);
      @(posedge clk);
      #1;
      wp_active = wa;
      bp_active = ba;
      bp_branch_cond = bc;
      wp_signals = {s1, s0};
      #1;
      if (e !== 1'bx) chk("master_trigger", master_trigger, e);
   endtask
   task t_value();
      wp_mode = 2'b00;
      wp_value1 = {8'h01, 8'h23};
      trig(2'h0, 4'h0, 4'h0, 8'h23, 8'h01, 1'b0);
      trig(2'h1, 4'h0, 4'h0, 8'h23, 8'h00, 1'b1);
      trig(2'h1, 4'h0, 4'h0, 8'h22, 8'h00, 1'b0);
      trig(2'h3, 4'h0, 4'h0, 8'h23, 8'h00, 1'b0);
      trig(2'h3, 4'h0, 4'h0, 8'h23, 8'h01, 1'b1);
   endtask
   task t_bp();
      // the transition scenario leaves watchpoint 0 in transition mode
      wp_mode = 2'b00;
      wp_value1 = {8'h01, 8'h23};
      trig(2'h0, 4'h5, 4'h4, 8'h00, 8'h00, 1'b1);
      trig(2'h0, 4'h5, 4'ha, 8'h00, 8'h00, 1'b0);
      trig(2'h3, 4'h1, 4'h1, 8'h23, 8'h01, 1'b1);
      trig(2'h1, 4'h1, 4'h1, 8'h22, 8'h01, 1'b0);
      trig(2'h3, 4'h1, 4'h0, 8'h23, 8'h01, 1'b0);
   endtask
   task t_trans();
      wp_mode = 2'b01;
      wp_value1[0] = 8'h10;
      wp_value2[0] = 8'h11;
      trig(2'h1, 4'h0, 4'h0, 8'h10, 8'h00, 1'bx);
      trig(2'h1, 4'h0, 4'h0, 8'h11, 8'h00, 1'b1);
      trig(2'h1, 4'h0, 4'h0, 8'h11, 8'h00, 1'b0);
      trig(2'h1, 4'h0, 4'h0, 8'h12, 8'h00, 1'bx);
      trig(2'h1, 4'h0, 4'h0, 8'h11, 8'h00, 1'b0);
   endtask
   task automatic cap(int k, int how, logic sl);
      int t;
      int nw;
      slow = sl;
      wp_mode = 2'b00;
      wp_value1[0] = 8'h23;
      @(posedge clk);
      #1;
      wp_active = 2'b00;
      bp_active = 4'h0;
      wp_signals = '0;
      clr = 1'b1;
      run_start = 1'b1;
      @(posedge clk);
      first = sample_data + 16'h0001;
      #1;
      run_start = 1'b0;
      clr = 1'b0;
      chk("running", running, 16'h0001);
      repeat (k - 1) @(posedge clk);
      #1;
      chk("triggered", triggered, 16'h0000);
      case (how)
         0: begin
            wp_active = 2'b01;
            wp_signals[0] = 8'h23;
         end
         1: counter_event = 1'b1;
         default: run_stop = 1'b1;
      endcase
      @(posedge clk);
      #1;
      wp_active = 2'b00;
      counter_event = 1'b0;
      run_stop = 1'b0;
      chk("running", running, 16'h0000);
      chk("triggered", triggered, 16'h0001);
      t = 0;
      // look only once the edge's updates have settled
      while (!(up_done === 1'b1 && up_valid === 1'b0) && t < 300) begin
         @(posedge clk);
         #1;
         t++;
      end
      chk("up_done", up_done, 16'h0001);
      // on wrap only the newest memory-depth samples survive
      nw = (k - 1 > TCL_DEPTH) ? TCL_DEPTH : k - 1;
      first = 16'(first + (k - 1 - nw));
      chk("words", 16'(u_host.n), 16'(nw));
      for (int i = 0; i < nw; i++) begin
         chk("word", u_host.got[i], 16'(first + i));
      end
   endtask
   initial begin
      {rst, counter_event, run_start, run_stop, slow, clr} = 6'b10_0000;
      {wp_signals, wp_value1, wp_value2} = '0;
      {wp_mode, wp_active, bp_branch_cond, bp_active} = '0;
      sample_data = 16'h0000;
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      t_value();
      t_trans();
      t_bp();
      cap(4, 0, 1'b0);
      cap(33, 1, 1'b1);
      cap(2, 2, 1'b0);
      cap(40, 0, 1'b1);
      print_verdict();
   end
endmodule // tb_trigger_capture_logic
